// ---- verilog/gain_window_regs.sv ----
/*
  AXI4-Lite register file for the chroma ratio and the gain-window timing,
  with the per-line pulse timer. Assumes a single master, one clock domain.
*/
// Chosen here: register access over AXI4-Lite.
// Overview of operation
// - Ratio upper byte holds bits 15..8, weights 2^-1..2^-8, resets to 0x87.
// - The 16-bit ratio is driven out as the chroma PLL reference.
// - Pulse start is 10 bits: low byte index 08 (0x3F), high index 09 (11).
// - Counting starts one clock after the hsync falling edge, in clock steps.
// - Pulse end is 10 bits; low byte at index 0A resets to 0x00.
// - The pulse is driven out to the converter sync-tip gain control.
// - Start high location bits 15..10 ignore writes and read zero.
// - End bits 9..8 at index 0B reset to 00; upper bits read zero.
// - Ratio lower byte at index 06 holds weights 2^-9..2^-16, resets 0xC1.
module gain_window_regs (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [5:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [5:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         hsync,
  output logic [15:0]       chroma_ratio,
  output logic              gain_window_pulse
);
  typedef struct packed {
    logic         aw_held;
    logic [3:0]   aw_idx;
    logic         w_held;
    logic [7:0]   w_byte;
    logic         w_lane0;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [7:0]   ratio_low;
    logic [7:0]   ratio_high;
    logic [7:0]   start_low;
    logic [1:0]   start_high;
    logic [7:0]   end_low;
    logic [1:0]   end_high;
  } regs_s;

  regs_s r;
  regs_s next_r;

  function automatic logic idx_mapped(input logic [3:0] idx);
    idx_mapped = (idx >= gain_window_pkg::IDX_RATIO_LOW) &&
                 (idx <= gain_window_pkg::IDX_END_HIGH);
  endfunction

  function automatic logic [3:0] addr_idx(input logic [5:0] addr);
    addr_idx = addr[5:2];
  endfunction

  logic [3:0]   rd_idx;
  logic [31:0]  rd_word;

  assign rd_idx = addr_idx(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_idx)
      gain_window_pkg::IDX_RATIO_LOW:  rd_word[7:0] = r.ratio_low;
      gain_window_pkg::IDX_RATIO_HIGH: rd_word[7:0] = r.ratio_high;
      gain_window_pkg::IDX_START_LOW:  rd_word[7:0] = r.start_low;
      gain_window_pkg::IDX_START_HIGH: rd_word[1:0] = r.start_high;
      gain_window_pkg::IDX_END_LOW:    rd_word[7:0] = r.end_low;
      gain_window_pkg::IDX_END_HIGH:   rd_word[1:0] = r.end_high;
      default:                         rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_awready = ~r.aw_held;
  assign s_axi_wready  = ~r.w_held;
  assign s_axi_arready = ~r.rvalid;

  always_comb begin
    next_r = r;
    // Address and data captured independently, in either order
    if (s_axi_awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_idx  = addr_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && !r.w_held) begin
      next_r.w_held  = 1'b1;
      next_r.w_byte  = s_axi_wdata[7:0];
      next_r.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // Commit once both halves are held and no response is pending
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = idx_mapped(r.aw_idx) ? gain_window_pkg::RESP_OKAY
                                            : gain_window_pkg::RESP_SLVERR;
      if (r.w_lane0) begin
        unique case (r.aw_idx)
          gain_window_pkg::IDX_RATIO_LOW:  next_r.ratio_low  = r.w_byte;
          gain_window_pkg::IDX_RATIO_HIGH: next_r.ratio_high = r.w_byte;
          gain_window_pkg::IDX_START_LOW:  next_r.start_low  = r.w_byte;
          gain_window_pkg::IDX_START_HIGH: next_r.start_high = r.w_byte[1:0];
          gain_window_pkg::IDX_END_LOW:    next_r.end_low    = r.w_byte;
          gain_window_pkg::IDX_END_HIGH:   next_r.end_high   = r.w_byte[1:0];
          default:                         next_r.bvalid     = 1'b1;
        endcase
      end
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_word;
      next_r.rresp  = idx_mapped(rd_idx) ? gain_window_pkg::RESP_OKAY
                                         : gain_window_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.aw_held    <= 1'b0;
      r.aw_idx     <= 4'h0;
      r.w_held     <= 1'b0;
      r.w_byte     <= 8'h00;
      r.w_lane0    <= 1'b0;
      r.bvalid     <= 1'b0;
      r.bresp      <= gain_window_pkg::RESP_OKAY;
      r.rvalid     <= 1'b0;
      r.rdata      <= 32'h0000_0000;
      r.rresp      <= gain_window_pkg::RESP_OKAY;
      r.ratio_low  <= gain_window_pkg::RST_RATIO_LOW;
      r.ratio_high <= gain_window_pkg::RST_RATIO_HIGH;
      r.start_low  <= gain_window_pkg::RST_START_LOW;
      r.start_high <= gain_window_pkg::RST_START_HIGH;
      r.end_low    <= gain_window_pkg::RST_END_LOW;
      r.end_high   <= gain_window_pkg::RST_END_HIGH;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata  = r.rdata;
  assign s_axi_rresp  = r.rresp;

  // PLL reference ratio, bits 15..8 upper byte
  assign chroma_ratio = {r.ratio_high, r.ratio_low};

  gain_window_timer u_timer (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .hsync             (hsync),
    .start_time        ({r.start_high, r.start_low}),
    .end_time          ({r.end_high, r.end_low}),
    .gain_window_pulse (gain_window_pulse)
  );
endmodule

// ---- verilog/gain_window_pkg.sv ----
/*
  Constants for the gain-window pulse timer and its register file.
  Assumes one clock domain and byte registers placed on aligned words.
*/
package gain_window_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 32;
  localparam int          CNT_W           = 10;
  localparam int          IDX_LSB         = 2;
  localparam int          IDX_W           = 4;

  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_RATIO_LOW   = 4'h6;
  localparam logic [3:0]  IDX_RATIO_HIGH  = 4'h7;
  localparam logic [3:0]  IDX_START_LOW   = 4'h8;
  localparam logic [3:0]  IDX_START_HIGH  = 4'h9;
  localparam logic [3:0]  IDX_END_LOW     = 4'hA;
  localparam logic [3:0]  IDX_END_HIGH    = 4'hB;

  localparam logic [7:0]  RST_RATIO_LOW   = 8'hC1;
  localparam logic [7:0]  RST_RATIO_HIGH  = 8'h87;
  localparam logic [7:0]  RST_START_LOW   = 8'h3F;
  localparam logic [1:0]  RST_START_HIGH  = 2'h3;
  localparam logic [7:0]  RST_END_LOW     = 8'h00;
  localparam logic [1:0]  RST_END_HIGH    = 2'h0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  localparam logic [9:0]  CNT_MAX         = 10'h3FF;

  typedef enum logic {
    LINE_IDLE  = 1'b0,
    LINE_COUNT = 1'b1
  } line_state_e;
endpackage

// ---- verilog/gain_window_timer.sv ----
/*
  Per-line timer that forms the gain-window pulse from horizontal sync.
  Assumes hsync is synchronous to sys_clk and start/end are stable values.
*/
module gain_window_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsync,
  input  wire logic [9:0]  start_time,
  input  wire logic [9:0]  end_time,
  output logic             gain_window_pulse
);
  typedef struct packed {
    logic                          hsync_prev;
    logic                          sync_seen;
    gain_window_pkg::line_state_e  state;
    logic [9:0]                    count;
    logic                          pulse;
  } timer_s;

  timer_s r;
  timer_s next_r;

  always_comb begin
    next_r = r;
    next_r.hsync_prev = hsync;
    // Falling edge held one clock before counting begins
    next_r.sync_seen = r.hsync_prev & ~hsync;
    if (r.state == gain_window_pkg::LINE_COUNT) begin
      if (r.count == end_time) begin
        next_r.pulse = 1'b0;
      end else if (r.count == start_time) begin
        next_r.pulse = 1'b1;
      end
    end
    unique case (r.state)
      gain_window_pkg::LINE_IDLE: begin
        next_r.count = r.count;
      end
      gain_window_pkg::LINE_COUNT: begin
        if (r.count == gain_window_pkg::CNT_MAX) begin
          next_r.state = gain_window_pkg::LINE_IDLE;
        end else begin
          next_r.count = r.count + 10'h001;
        end
      end
    endcase
    if (r.sync_seen) begin
      next_r.state = gain_window_pkg::LINE_COUNT;
      next_r.count = 10'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r.hsync_prev <= 1'b1;
      r.sync_seen  <= 1'b0;
      r.state      <= gain_window_pkg::LINE_IDLE;
      r.count      <= 10'h000;
      r.pulse      <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign gain_window_pulse = r.pulse;
endmodule

// ---- verif/gain_window_monitor.sv ----
/* Checker for gain_window_regs.
   Bound to the block; sees its ports only. */
module gain_window_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        hsync,
  input wire logic [15:0] chroma_ratio,
  input wire logic        gain_window_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       hsync_q;
  logic [9:0] line_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since the sync fall was sampled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsync_q  <= 1'b1;
      line_cnt <= 10'h3FF;
    end else begin
      hsync_q <= hsync;
      if (hsync_q && !hsync) line_cnt <= 10'h000;
      else if (line_cnt != 10'h3FF) line_cnt <= line_cnt + 10'h001;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  a_ratio_reset: assert property ($rose(rst_n) |-> chroma_ratio == 16'h87C1)
    else $error("ratio reset value wrong");
  a_ratio_write: assert property ($changed(chroma_ratio) |-> $rose(s_axi_bvalid))
    else $error("ratio changed without write");
  a_pulse_reset: assert property ($rose(rst_n) |-> !gain_window_pulse)
    else $error("pulse high after reset");
  a_pulse_rise: assert property ($rose(gain_window_pulse) |-> line_cnt >= 10'h002)
    else $error("pulse rose too early");
  a_pulse_fall: assert property ($fell(gain_window_pulse) |-> line_cnt >= 10'h002)
    else $error("pulse fell too early");
endmodule
bind gain_window_regs gain_window_monitor gain_window_monitor_inst (.sys_clk, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .hsync, .chroma_ratio, .gain_window_pulse);

// ---- verif/sync_tip_model.sv ----
/* Converter-side model: makes sync lines and times the pulse.
   Assumes line_go is a one-cycle request. */
module sync_tip_model (
  input  wire logic sys_clk,
  input  wire logic line_go,
  input  wire logic gain_window_pulse,
  output logic      hsync,
  output int        rise_at,
  output int        fall_at
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 100;
  initial hsync = 1'b1;
  always @(posedge sys_clk) begin
    cyc   <= cyc + 1;
    hsync <= cyc >= 6;
    if (line_go) begin
      cyc     <= 0;
      hsync   <= 1'b0;
      rise_at <= -1;
      fall_at <= -1;
    end else if (gain_window_pulse && rise_at < 0) rise_at <= cyc;
    else if (!gain_window_pulse && rise_at >= 0 && fall_at < 0) fall_at <= cyc;
  end
endmodule

// ---- verif/gain_window_regs_tb_top.sv ----
/* Self-checking bench for gain_window_regs.
   Assumes the monitor and sync_tip_model are compiled first. */
module gain_window_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_n, line_go, hsync, gain_window_pulse;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] chroma_ratio;
  int          rise_at, fall_at, err_count, total_checks;
  gain_window_regs gain_window_regs_inst (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hsync, .chroma_ratio, .gain_window_pulse);
  sync_tip_model sync_tip_model_inst (.sys_clk, .line_go, .gain_window_pulse, .hsync,
    .rise_at, .fall_at);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = !sys_clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 40) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    tmo(n);
    check({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    s_axi_rready <= 1'b0;
    tmo(n);
    check(s_axi_rdata, d);
    check({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task t_reset;
    check({16'h0, chroma_ratio}, 32'h87C1);
    rd(6'h18, 32'hC1, 2'h0);
    rd(6'h1C, 32'h87, 2'h0);
    rd(6'h20, 32'h3F, 2'h0);
    rd(6'h24, 32'h3, 2'h0);
    rd(6'h28, 32'h0, 2'h0);
    rd(6'h2C, 32'h0, 2'h0);
  endtask
  task t_regs;
    wr(6'h1C, 32'hFFFFFF5A, 4'h1, 2'h0);
    check({16'h0, chroma_ratio}, 32'h5AC1);
    wr(6'h18, 32'h5A5A5A33, 4'h1, 2'h0);
    check({16'h0, chroma_ratio}, 32'h5A33);
    rd(6'h18, 32'h33, 2'h0);
    rd(6'h1C, 32'h5A, 2'h0);
    wr(6'h24, 32'hFFFFFFFE, 4'h1, 2'h0);
    rd(6'h24, 32'h2, 2'h0);
    wr(6'h2C, 32'h3, 4'h1, 2'h0);
    wr(6'h2C, 32'h0, 4'h0, 2'h0);
    rd(6'h2C, 32'h3, 2'h0);
    wr(6'h30, 32'h1, 4'h1, 2'h2);
    rd(6'h30, 32'h0, 2'h2);
  endtask
  task automatic t_pulse(input logic [9:0] s, input logic [9:0] e);
    wr(6'h20, {24'h0, s[7:0]}, 4'h1, 2'h0);
    wr(6'h24, {30'h0, s[9:8]}, 4'h1, 2'h0);
    wr(6'h28, {24'h0, e[7:0]}, 4'h1, 2'h0);
    wr(6'h2C, {30'h0, e[9:8]}, 4'h1, 2'h0);
    line_go <= 1'b1;
    @(posedge sys_clk);
    line_go <= 1'b0;
    repeat (e + 8) @(posedge sys_clk);
    check(rise_at, (s < e) ? {22'h0, s} + 32'h3 : 32'hFFFFFFFF);
    check(fall_at, (s < e) ? {22'h0, e} + 32'h3 : 32'hFFFFFFFF);
  endtask
  initial begin
    {rst_n, line_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_pulse(10'h002, 10'h004);
    t_pulse(10'h000, 10'h105);
    t_pulse(10'h007, 10'h007);
    summarize();
  end
endmodule
